/* shared/sbl_pkg.sv */
// constants and types shared by the serial boot configuration loader
// ==========================================================================
package sbl_pkg;

  // ========================================================================
  // register map
  localparam logic [7:0]  STATUS_OFS      = 8'h18;
  localparam logic [7:0]  CONTROL_OFS     = 8'h1C;
  localparam logic [7:0]  CONFIG0_OFS     = 8'h20;
  localparam logic [7:0]  CONFIG3_OFS     = 8'h2C;
  localparam int          DIV_LSB         = 0;
  localparam int          DIV_MSB         = 3;
  localparam int          FAST_BIT        = 4;
  localparam logic [3:0]  DIV_RESET       = 4'hE;
  localparam logic [15:0] LEN_RESET       = 16'h0000;

  // ========================================================================
  // link constants
  localparam logic [7:0]  OP_READ         = 8'h03;
  localparam logic [7:0]  OP_FAST_READ    = 8'h0B;
  localparam logic [4:0]  ADDR_BYTES      = 5'h03;
  localparam logic [4:0]  CFG_BYTES       = 5'h10;
  localparam int          CFG_BITS        = 128;
  localparam int          SRAM_WORDS      = 8192;
  localparam int          SRAM_AW         = 13;

  typedef enum logic [2:0] {
    SBL_SETUP, SBL_CMD, SBL_HUNT, SBL_LEN_LO, SBL_LEN_HI,
    SBL_CFG, SBL_CODE, SBL_DONE
  } sbl_state_t;

  // ========================================================================
  // divider code to {high ticks, low ticks}; odd divisors favour high
  function automatic logic [11:0] sbl_div_ticks(input logic [3:0] code);
    logic [11:0] t;
    t = 12'h000;
    case (code)
      4'h0:    t = {6'h01, 6'h01};
      4'h1:    t = {6'h01, 6'h01};
      4'h2:    t = {6'h02, 6'h01};
      4'h3:    t = {6'h02, 6'h02};
      4'h4:    t = {6'h03, 6'h02};
      4'h5:    t = {6'h04, 6'h03};
      4'h6:    t = {6'h05, 6'h05};
      4'h7:    t = {6'h07, 6'h06};
      4'h8:    t = {6'h07, 6'h07};
      4'h9:    t = {6'h09, 6'h08};
      4'hA:    t = {6'h0D, 6'h0C};
      4'hB:    t = {6'h11, 6'h10};
      4'hC:    t = {6'h11, 6'h11};
      4'hD:    t = {6'h19, 6'h19};
      default: t = {6'h22, 6'h21};
    endcase
    return t;
  endfunction

endpackage

/* rtl/sbl_sram.sv */
// on-chip code sram: one write port, one registered read port
`timescale 1ns/1ns
`default_nettype none
module sbl_sram
(
  input  wire logic                            clk_in,
  input  wire logic                            we_in,
  input  wire logic [sbl_pkg::SRAM_AW-1:0]     waddr_in,
  input  wire logic [31:0]                     wdata_in,
  input  wire logic [sbl_pkg::SRAM_AW-1:0]     raddr_in,
  output logic      [31:0]                     rdata_out
);

  // ========================================================================
  // storage, no reset so it maps onto block ram
  logic [31:0] mem [0:sbl_pkg::SRAM_WORDS-1];

  always_ff @(posedge clk_in)
  begin
    if (we_in)
    begin
      mem[waddr_in] <= wdata_in;
    end
    rdata_out <= mem[raddr_in];
  end

endmodule
`default_nettype wire

/* rtl/sbl_loader.sv */
// serial boot loader: spi read stream, config capture, sram load, ahb regs
//
// Decided for this implementation: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module sbl_loader
(
  input  wire logic                        sys_clk_in,
  input  wire logic                        resetn_in,
  input  wire logic                        soft_reset_in,
  // spi memory link
  output logic                             spi_clk_out,
  output logic                             spi_cs_n_out,
  output logic                             spi_do_out,
  input  wire logic                        spi_di_in,
  output logic                             di_pullup_en_out,
  // system hand-off
  output logic [sbl_pkg::CFG_BITS-1:0]     reset_config_words_out,
  output logic                             config_valid_out,
  output logic                             sys_release_out,
  output logic                             sram_enable_out,
  output logic                             sram_base_mapping_out,
  output logic                             boot_external_out,
  input  wire logic [sbl_pkg::SRAM_AW-1:0] cpu_addr_in,
  output logic [31:0]                      cpu_rdata_out,
  // ahb-lite slave
  input  wire logic                        hsel,
  input  wire logic [31:0]                 haddr,
  input  wire logic [1:0]                  htrans,
  input  wire logic                        hwrite,
  input  wire logic [2:0]                  hsize,
  input  wire logic [31:0]                 hwdata,
  input  wire logic                        hready,
  output logic                             hreadyout,
  output logic                             hresp,
  output logic [31:0]                      hrdata
);

  // ========================================================================
  // state
  typedef struct packed {
    sbl_pkg::sbl_state_t           st;
    logic                          hard;
    logic                          sclk;
    logic                          cs_n;
    logic [7:0]                    tx;
    logic [7:0]                    rx;
    logic [2:0]                    bit_cnt;
    logic [4:0]                    byte_cnt;
    logic [5:0]                    tick;
    logic [3:0]                    div;
    logic [3:0]                    ctrl_div;
    logic                          ctrl_fast;
    logic                          ctrl_locked;
    logic [15:0]                   len;
    logic [sbl_pkg::CFG_BITS-1:0]  cfg;
    logic [23:0]                   word;
    logic [1:0]                    word_byte;
    logic [15:0]                   word_cnt;
    logic                          mem_we;
    logic [sbl_pkg::SRAM_AW-1:0]   mem_addr;
    logic [31:0]                   mem_wdata;
    logic                          ahb_wr;
    logic [7:0]                    ahb_addr;
    logic [31:0]                   rdata;
  } sbl_loader_t;

  sbl_loader_t s;
  sbl_loader_t next_s;

  logic [11:0] ticks;
  logic        link_active;
  logic        addr_phase;
  logic        fast_boot;

  assign ticks       = sbl_pkg::sbl_div_ticks(s.div);
  assign link_active = (s.st != sbl_pkg::SBL_SETUP) &&
                       (s.st != sbl_pkg::SBL_DONE);
  assign addr_phase  = hsel && htrans[1] && hready;
  assign fast_boot   = !s.hard && s.ctrl_fast;

  // ========================================================================
  // next state
  always_comb
  begin
    next_s        = s;
    next_s.mem_we = 1'b0;
    case (s.st)
      sbl_pkg::SBL_SETUP:
      begin
        // soft boot uses software divider, hard boot starts slowest
        next_s.div      = s.hard ? sbl_pkg::DIV_RESET : s.ctrl_div;
        next_s.tx       = fast_boot ? sbl_pkg::OP_FAST_READ
                                    : sbl_pkg::OP_READ;
        next_s.cs_n     = 1'b0;
        next_s.sclk     = 1'b0;
        next_s.bit_cnt  = 3'h0;
        next_s.byte_cnt = 5'h00;
        next_s.tick     = 6'h00;
        next_s.len      = sbl_pkg::LEN_RESET;
        next_s.word_cnt = 16'h0000;
        next_s.word_byte = 2'h0;
        next_s.st       = sbl_pkg::SBL_CMD;
      end
      sbl_pkg::SBL_DONE:
      begin
        next_s.cs_n = 1'b1;
        next_s.sclk = 1'b0;
      end
      default:
      begin
        if (s.tick != 6'h00)
        begin
          next_s.tick = s.tick - 6'h01;
        end
        else if (!s.sclk)
        begin
          // rising edge samples the memory's bit
          next_s.sclk = 1'b1;
          next_s.rx   = {s.rx[6:0], spi_di_in};
          next_s.tick = ticks[11:6] - 6'h01;
        end
        else
        begin
          // falling edge moves the next command bit out
          next_s.sclk    = 1'b0;
          next_s.tick    = ticks[5:0] - 6'h01;
          next_s.tx      = {s.tx[6:0], 1'b0};
          next_s.bit_cnt = s.bit_cnt + 3'h1;
          if (s.bit_cnt == 3'h7)
          begin
            next_s.tx = 8'h00;
            case (s.st)
              sbl_pkg::SBL_CMD:
              begin
                next_s.byte_cnt = s.byte_cnt + 5'h01;
                // fast read adds one dummy byte after the address
                // opcode is byte 0, so the last address byte is byte 3
                if (s.byte_cnt == (fast_boot ? sbl_pkg::ADDR_BYTES + 5'h01
                                   : sbl_pkg::ADDR_BYTES))
                begin
                  next_s.st = sbl_pkg::SBL_HUNT;
                end
              end
              sbl_pkg::SBL_HUNT:
              begin
                // upper nibble zero marks the divider byte
                if (s.rx[7:4] == 4'h0)
                begin
                  if (s.hard)
                  begin
                    next_s.div = s.rx[3:0];
                    next_s.tick = 6'h00;
                    if (!s.ctrl_locked)
                    begin
                      next_s.ctrl_div = s.rx[3:0];
                    end
                  end
                  next_s.st = sbl_pkg::SBL_LEN_LO;
                end
              end
              sbl_pkg::SBL_LEN_LO:
              begin
                next_s.len[7:0] = s.rx;
                next_s.st       = sbl_pkg::SBL_LEN_HI;
              end
              sbl_pkg::SBL_LEN_HI:
              begin
                next_s.len[15:8] = s.rx;
                next_s.byte_cnt  = 5'h00;
                next_s.st        = sbl_pkg::SBL_CFG;
              end
              sbl_pkg::SBL_CFG:
              begin
                // first byte ends in the low lane of the config vector
                next_s.cfg      = {s.rx, s.cfg[sbl_pkg::CFG_BITS-1:8]};
                next_s.byte_cnt = s.byte_cnt + 5'h01;
                if (s.byte_cnt == sbl_pkg::CFG_BYTES - 5'h01)
                begin
                  // no code: stop here, nothing past the config is read
                  next_s.st = (s.len == 16'h0000) ? sbl_pkg::SBL_DONE
                                                  : sbl_pkg::SBL_CODE;
                end
              end
              sbl_pkg::SBL_CODE:
              begin
                next_s.word      = {s.word[15:0], s.rx};
                next_s.word_byte = s.word_byte + 2'h1;
                if (s.word_byte == 2'h3)
                begin
                  // words beyond the sram are read but dropped
                  next_s.mem_we    = (s.word_cnt[15:sbl_pkg::SRAM_AW] == '0);
                  next_s.mem_addr  = s.word_cnt[sbl_pkg::SRAM_AW-1:0];
                  next_s.mem_wdata = {s.word, s.rx};
                  next_s.word_cnt  = s.word_cnt + 16'h0001;
                  if (s.word_cnt == s.len)
                  begin
                    next_s.st = sbl_pkg::SBL_DONE;
                  end
                end
              end
              default:
              begin
                next_s.st = sbl_pkg::SBL_DONE;
              end
            endcase
          end
        end
      end
    endcase

    // ----------------------------------------------------------------------
    // ahb data phase: control is write-once, later writes dropped
    next_s.ahb_wr = 1'b0;
    if (s.ahb_wr && (s.ahb_addr == sbl_pkg::CONTROL_OFS) && !s.ctrl_locked)
    begin
      next_s.ctrl_div    = hwdata[sbl_pkg::DIV_MSB:sbl_pkg::DIV_LSB];
      next_s.ctrl_fast   = hwdata[sbl_pkg::FAST_BIT];
      next_s.ctrl_locked = 1'b1;
    end
    if (addr_phase)
    begin
      next_s.ahb_wr   = hwrite;
      next_s.ahb_addr = haddr[7:0];
      next_s.rdata    = 32'h0000_0000;
      if (!hwrite)
      begin
        case (haddr[7:0])
          sbl_pkg::STATUS_OFS:  next_s.rdata = {16'h0000, s.len};
          sbl_pkg::CONTROL_OFS: next_s.rdata = {27'h0000000, s.ctrl_fast,
                                                s.ctrl_div};
          sbl_pkg::CONFIG0_OFS: next_s.rdata = s.cfg[31:0];
          8'h24:                next_s.rdata = s.cfg[63:32];
          8'h28:                next_s.rdata = s.cfg[95:64];
          sbl_pkg::CONFIG3_OFS: next_s.rdata = s.cfg[127:96];
          default:              next_s.rdata = 32'h0000_0000;
        endcase
      end
    end

    // ----------------------------------------------------------------------
    // soft reset restarts the boot but keeps divider and fast read
    if (soft_reset_in)
    begin
      next_s.st   = sbl_pkg::SBL_SETUP;
      next_s.hard = 1'b0;
      next_s.cs_n = 1'b1;
      next_s.sclk = 1'b0;
    end
  end

  // ========================================================================
  // registers
  always_ff @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      s             <= '0;
      s.st          <= sbl_pkg::SBL_SETUP;
      s.hard        <= 1'b1;
      s.cs_n        <= 1'b1;
      s.div         <= sbl_pkg::DIV_RESET;
      s.ctrl_div    <= sbl_pkg::DIV_RESET;
      s.len         <= sbl_pkg::LEN_RESET;
    end
    else
    begin
      s <= next_s;
    end
  end

  // ========================================================================
  // code sram
  sbl_sram u_sram
  (
    .clk_in    (sys_clk_in),
    .we_in     (s.mem_we),
    .waddr_in  (s.mem_addr),
    .wdata_in  (s.mem_wdata),
    .raddr_in  (cpu_addr_in),
    .rdata_out (cpu_rdata_out)
  );

  // ========================================================================
  // outputs
  assign spi_clk_out            = s.sclk;
  assign spi_cs_n_out           = s.cs_n;
  assign spi_do_out             = s.tx[7];
  // pull-up only while waiting for the memory to start driving
  assign di_pullup_en_out       = link_active &&
                                  ((s.st == sbl_pkg::SBL_CMD) ||
                                   (s.st == sbl_pkg::SBL_HUNT));
  assign reset_config_words_out = s.cfg;
  assign config_valid_out       = (s.st == sbl_pkg::SBL_DONE);
  assign sys_release_out        = (s.st == sbl_pkg::SBL_DONE);
  assign sram_enable_out        = (s.st == sbl_pkg::SBL_DONE) &&
                                  (s.len != 16'h0000);
  assign sram_base_mapping_out  = sram_enable_out;
  assign boot_external_out      = (s.st == sbl_pkg::SBL_DONE) &&
                                  (s.len == 16'h0000);
  assign hreadyout              = 1'b1;
  assign hresp                  = 1'b0;
  assign hrdata                 = s.rdata;

endmodule
`default_nettype wire

/* verification/sbl_spi_mem.sv */
// behavioural spi read-only memory answering the boot loader
`timescale 1ns/1ns
`default_nettype none
module sbl_spi_mem
(
  input  wire logic   sck_in,
  input  wire logic   cs_n_in,
  input  wire logic   mosi_in,
  input  wire logic   pullup_in,
  output logic        miso_out,
  output logic [7:0]  opcode_out,
  output logic [23:0] addr_out,
  output var int      rises_out
);
  logic [7:0]  img [0:1279];
  logic [39:0] cmd;
  logic        drv = 1'b0;
  logic        last = 1'b0;
  int          nbits;
  int          n;
  assign nbits = (opcode_out == 8'h0B) ? 40 : 32;
  // released line goes to the pull-up, or without it flips so it never keeps the old bit
  assign miso_out = (drv && !cs_n_in) ? last : (pullup_in | ~last);
  always @(negedge cs_n_in)
  begin
    rises_out = 0;
    opcode_out = 8'h00;
    drv = 1'b0;
  end
  always @(posedge sck_in)
  begin
    if (!cs_n_in)
    begin
      rises_out++;
      cmd = {cmd[38:0], mosi_in};
      if (rises_out == 8)
        opcode_out = cmd[7:0];
      if (rises_out == 32)
        addr_out = cmd[23:0];
    end
  end
  // data moves on the falling edge and holds over the next rise
  always @(negedge sck_in)
  begin
    if (!cs_n_in && rises_out >= nbits)
    begin
      n = rises_out - nbits;
      last = img[n / 8][7 - n % 8];
      drv = 1'b1;
    end
  end
endmodule
`default_nettype wire

/* verification/sbl_loader_checker.sv */
// port assertions for the serial boot loader
`timescale 1ns/1ns
`default_nettype none
module sbl_loader_checker
(
  input wire logic         sys_clk_in,
  input wire logic         resetn_in,
  input wire logic         soft_reset_in,
  input wire logic         spi_clk_out,
  input wire logic         spi_cs_n_out,
  input wire logic [127:0] reset_config_words_out,
  input wire logic         config_valid_out,
  input wire logic         sys_release_out,
  input wire logic         sram_enable_out,
  input wire logic         sram_base_mapping_out,
  input wire logic         boot_external_out
);
  // high phase length; slowest divisor gives 34 ticks
  logic [6:0] hi_cnt;
  always_ff @(posedge sys_clk_in or negedge resetn_in)
    if (!resetn_in)
      hi_cnt <= 7'h00;
    else
      hi_cnt <= spi_clk_out ? hi_cnt + 7'h01 : 7'h00;
  default clocking @(posedge sys_clk_in);
  endclocking
  default disable iff (!resetn_in);
  property p_rel;
    sys_release_out |-> config_valid_out;
  endproperty
  a_rel: assert property (p_rel) else $error("early release");
  property p_soft;
    soft_reset_in |=> !config_valid_out && spi_cs_n_out;
  endproperty
  a_soft: assert property (p_soft) else $error("soft restart");
  property p_ext;
    config_valid_out |-> boot_external_out != sram_enable_out;
  endproperty
  a_ext: assert property (p_ext) else $error("fetch route");
  property p_map;
    sram_enable_out |-> sram_base_mapping_out && config_valid_out;
  endproperty
  a_map: assert property (p_map) else $error("sram map");
  property p_idle;
    spi_cs_n_out |-> !spi_clk_out;
  endproperty
  a_idle: assert property (p_idle) else $error("clock idle");
  // select lifts one cycle after the last fall, so check the cycle after
  property p_done;
    config_valid_out |=> spi_cs_n_out;
  endproperty
  a_done: assert property (p_done) else $error("select held");
  property p_cfg;
    config_valid_out && $past(config_valid_out)
      |-> $stable(reset_config_words_out);
  endproperty
  a_cfg: assert property (p_cfg) else $error("config moved");
  property p_hi;
    hi_cnt <= 7'h22;
  endproperty
  a_hi: assert property (p_hi) else $error("high phase");
  c_sram: cover property ($rose(config_valid_out) && sram_enable_out);
  c_ext: cover property ($rose(config_valid_out) && boot_external_out);
  c_soft: cover property (soft_reset_in);
endmodule
bind sbl_loader sbl_loader_checker u_chk (.sys_clk_in(sys_clk_in),
  .resetn_in(resetn_in), .soft_reset_in(soft_reset_in),
  .spi_clk_out(spi_clk_out), .spi_cs_n_out(spi_cs_n_out),
  .reset_config_words_out(reset_config_words_out),
  .config_valid_out(config_valid_out), .sys_release_out(sys_release_out),
  .sram_enable_out(sram_enable_out), .boot_external_out(boot_external_out),
  .sram_base_mapping_out(sram_base_mapping_out));
`default_nettype wire

/* verification/testbench.sv */
// self-checking bench for the serial boot loader
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic        sys_clk_in = 1'b0, resetn_in = 1'b0, soft_reset_in = 1'b0;
  logic        hsel = 1'b0, hwrite = 1'b0, hready, hresp;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, cpu_rdata;
  logic [12:0] cpu_addr = 13'h0000;
  logic        sck, cs_n, mosi, miso, pu_en, valid, rel, sram_en, map, ext;
  logic [127:0] cfg;
  int          fails = 0, total_checks = 0, hc = 0, lhi = 0, mhi = 0;
  sbl_loader uut
  (
    .sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
    .soft_reset_in(soft_reset_in), .spi_clk_out(sck), .spi_cs_n_out(cs_n),
    .spi_do_out(mosi), .spi_di_in(miso), .di_pullup_en_out(pu_en),
    .reset_config_words_out(cfg), .config_valid_out(valid),
    .sys_release_out(rel), .sram_enable_out(sram_en),
    .sram_base_mapping_out(map), .boot_external_out(ext),
    .cpu_addr_in(cpu_addr), .cpu_rdata_out(cpu_rdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp),
    .hrdata(hrdata)
  );
  sbl_spi_mem mem
  (
    .sck_in(sck), .cs_n_in(cs_n), .mosi_in(mosi), .pullup_in(pu_en),
    .miso_out(miso), .opcode_out(), .addr_out(), .rises_out()
  );
  always #20 sys_clk_in = ~sys_clk_in;
  // latest and longest shift clock high phase in ticks
  always @(negedge sys_clk_in)
  begin
    hc = (sck === 1'b1) ? hc + 1 : 0;
    lhi = (hc != 0) ? hc : lhi;
    mhi = (hc > mhi) ? hc : mhi;
  end
  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    if (fails == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [31:0] e);
    @(posedge sys_clk_in);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= w;
    do @(posedge sys_clk_in); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk_in); while (hready !== 1'b1);
    if (!w)
      chk(hrdata, e);
    chk(hresp, 1'b0);
  endtask
  task automatic hard_reset(input logic [3:0] div, input logic [15:0] len,
                            input logic [7:0] s);
    mem.img[0] = {4'h0, div};
    mem.img[1] = len[7:0];
    mem.img[2] = len[15:8];
    for (int i = 3; i < 1280; i++)
      mem.img[i] = s + 8'(i);
    @(posedge sys_clk_in);
    resetn_in <= 1'b0;
    repeat (12) @(posedge sys_clk_in);
    resetn_in <= 1'b1;
  endtask
  task automatic boot(input logic [7:0] op, input int nb, input int hi);
    for (int i = 0; i < 40000 && valid !== 1'b1; i++)
      @(negedge sys_clk_in);
    chk({valid, rel}, 2'h3);
    chk(mem.opcode_out, op);
    chk(mem.addr_out, 24'h000000);
    chk(mem.rises_out, 8 * nb + ((op == 8'h0B) ? 40 : 32));
    chk(lhi, hi);
  endtask
  task automatic img_chk(input logic [7:0] s, input int last);
    logic [127:0] e;
    logic [7:0]   b;
    int           n;
    for (int k = 0; k < 16; k++)
      e[8 * k +: 8] = s + 8'(3 + k);
    chk(cfg, e);
    for (int k = 0; k < 4; k++)
      ahb(1'b0, sbl_pkg::CONFIG0_OFS + 8'(4 * k), 32'h0,
          e[32 * k +: 32]);
    for (int j = 0; j < 3 && last > 0; j++)
    begin
      n = (j == 2) ? last : j;
      @(posedge sys_clk_in);
      cpu_addr <= 13'(n);
      repeat (2) @(negedge sys_clk_in);
      b = s + 8'(19 + 4 * n);
      chk(cpu_rdata, {b, b + 8'h01, b + 8'h02, b + 8'h03});
    end
  endtask
  task automatic t_hard_plain;
    boot(8'h03, 19, 3);
    chk(mhi, 34);
    chk({ext, sram_en, map}, 3'h4);
    ahb(1'b0, sbl_pkg::STATUS_OFS, 32'h0, 32'h0);
    ahb(1'b0, sbl_pkg::CONTROL_OFS, 32'h0, 32'h4);
    ahb(1'b0, 8'h40, 32'h0, 32'h0);
    img_chk(8'h30, 0);
  endtask
  task automatic t_hard_load;
    hard_reset(4'h1, 16'h0100, 8'h50);
    ahb(1'b1, sbl_pkg::CONTROL_OFS, 32'h12, 32'h0);
    ahb(1'b1, sbl_pkg::CONTROL_OFS, 32'h05, 32'h0);
    ahb(1'b0, sbl_pkg::CONTROL_OFS, 32'h0, 32'h12);
    boot(8'h03, 1047, 1);
    chk({ext, sram_en, map}, 3'h3);
    ahb(1'b0, sbl_pkg::STATUS_OFS, 32'h0, 32'h100);
    img_chk(8'h50, 256);
  endtask
  task automatic t_soft_fast;
    @(posedge sys_clk_in);
    soft_reset_in <= 1'b1;
    @(posedge sys_clk_in);
    soft_reset_in <= 1'b0;
    @(negedge sys_clk_in);
    chk(valid, 1'b0);
    boot(8'h0B, 1047, 2);
    ahb(1'b0, sbl_pkg::CONTROL_OFS, 32'h0, 32'h12);
    chk({ext, sram_en, map}, 3'h3);
    img_chk(8'h50, 256);
  endtask
  initial
  begin
    hard_reset(4'h4, 16'h0000, 8'h30);
    t_hard_plain();
    t_hard_load();
    t_soft_fast();
    complete_run();
  end
  initial
  begin
    repeat (80000) @(posedge sys_clk_in);
    fails++;
    complete_run();
  end
endmodule
`default_nettype wire
